// ==== core/dcpo_defs.svh ====
`ifndef DCPO_DEFS_SVH
`define DCPO_DEFS_SVH

// Mode register addresses
`define DCPO_MA_W         6
`define DCPO_MA_INV       6'h0f
`define DCPO_MA_BANK      6'h10
`define DCPO_MA_SEG       6'h11
`define DCPO_MA_CNT_LO    6'h12
`define DCPO_MA_CNT_HI    6'h13

// Reset values
`define DCPO_INV_RST      8'h55
`define DCPO_BANK_RST     8'h00
`define DCPO_SEG_RST      8'h00
`define DCPO_CNT_RST      16'h0000
`define DCPO_RD_ZERO      8'h00

// Field layout
`define DCPO_OP_W         8
`define DCPO_CNT_W        16
`define DCPO_CHANNELS     2
`define DCPO_ROW_W        15
`define DCPO_SEG_LSB      11
`define DCPO_SEG_LSB_BYTE 12

`endif

// ==== core/dcpo_pkg.sv ====
package dcpo_pkg;

	typedef enum logic [2:0] {
		DCPO_REG_INV,
		DCPO_REG_BANK,
		DCPO_REG_SEG,
		DCPO_REG_CNT_LO,
		DCPO_REG_CNT_HI,
		DCPO_REG_NONE
	} dcpo_reg_e;

	typedef logic [7:0] dcpo_byte_t;

endpackage : dcpo_pkg

// ==== core/dcpo_pulse_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// Event crossing by toggle: source pulses must be at least two
// destination cycles apart or they merge.
module dcpo_pulse_sync
	import dcpo_pkg::*;
(
	input  wire logic src_clk,
	input  wire logic dst_clk,
	input  wire logic reset,
	input  wire logic src_pulse,
	output logic      dst_pulse
);

	logic tog_q;
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge src_clk or posedge reset) begin
		if (reset) begin
			tog_q <= 1'b0;
		end else if (src_pulse) begin
			tog_q <= ~tog_q;
		end
	end

	always_ff @(posedge dst_clk or posedge reset) begin
		if (reset) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= tog_q;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign dst_pulse = s2_q ^ s3_q;

endmodule : dcpo_pulse_sync

`default_nettype wire

// ==== core/dcpo_word_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dcpo_defs.svh"

// Four-phase-free toggle handshake for a word; data is held stable
// in the source domain until the acknowledge returns.
module dcpo_word_sync
	import dcpo_pkg::*;
#(
	parameter int W = `DCPO_CNT_W
) (
	input  wire logic         src_clk,
	input  wire logic         dst_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] src_data,
	input  wire logic         src_valid,
	output logic              src_ready,
	output logic [W-1:0]      dst_data,
	output logic              dst_valid
);

	logic         req_q;
	logic [W-1:0] hold_q;
	logic         ack_s1_q;
	logic         ack_s2_q;
	logic         req_s1_q;
	logic         req_s2_q;
	logic         req_s3_q;

	assign src_ready = (req_q == ack_s2_q);

	always_ff @(posedge src_clk or posedge reset) begin
		if (reset) begin
			req_q  <= 1'b0;
			hold_q <= '0;
		end else if (src_valid && src_ready) begin
			req_q  <= ~req_q;
			hold_q <= src_data;
		end
	end

	always_ff @(posedge src_clk or posedge reset) begin
		if (reset) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= req_s3_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	always_ff @(posedge dst_clk or posedge reset) begin
		if (reset) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	assign dst_valid = req_s2_q ^ req_s3_q;
	assign dst_data  = hold_q;

endmodule : dcpo_word_sync

`default_nettype wire

// ==== core/dcpo_mode_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dcpo_defs.svh"

// Function
// - Eight-bit lower-byte invert register at 0x0f
// - Invert register resets to 0x55
// - Invert bit n inverts data line n
// - Mask/inversion pin always sends true pattern
// - No bus inversion during calibration reads
// - Write-only bank mask at 0x10, one per bank
// - Bank mask bits default to zero
// - Each channel keeps its own bank mask
// - Segment mask at 0x11 by upper row bits
// - Segment mask zero means segment refreshed
// - Each channel keeps its own segment mask
// - Address 0x12 reads low count byte
// - Address 0x13 reads high count byte
// - Oscillator start command clears the count
// - Read drives operand on lines, rest zero
module dcpo_mode_regs
	import dcpo_pkg::*;
(
	input  wire logic                     clk_sys,
	input  wire logic                     clk_link,
	input  wire logic                     reset,
	input  wire logic                     mrw_valid,
	input  wire logic                     mrr_valid,
	input  wire logic                     mr_chan,
	input  wire logic [`DCPO_MA_W-1:0]    mr_addr,
	input  wire logic [`DCPO_OP_W-1:0]    mrw_data,
	input  wire logic                     mpc_osc_start,
	input  wire logic                     cal_active,
	input  wire logic                     cal_chan,
	input  wire logic                     cal_pattern,
	input  wire logic                     dbi_enable,
	input  wire logic                     ref_req,
	input  wire logic                     ref_chan,
	input  wire logic [2:0]               ref_bank,
	input  wire logic [`DCPO_ROW_W-1:0]   ref_row,
	input  wire logic                     byte_mode,
	input  wire logic                     osc_tick,
	input  wire logic                     osc_stop,
	output logic [`DCPO_OP_W-1:0]         dq_o,
	output logic                          dq_oe,
	output logic                          dmi_o,
	output logic                          dmi_oe,
	output logic                          dbi_active,
	output logic [1:0][`DCPO_OP_W-1:0]    bank_mask,
	output logic [1:0][`DCPO_OP_W-1:0]    seg_mask,
	output logic                          ref_done,
	output logic                          ref_skip,
	output logic                          osc_running
);

	////////////////////////////////////////////////////////////////////////////

	function automatic dcpo_reg_e decode_reg(input logic [`DCPO_MA_W-1:0] ma);
		case (ma)
			`DCPO_MA_INV:    decode_reg = DCPO_REG_INV;
			`DCPO_MA_BANK:   decode_reg = DCPO_REG_BANK;
			`DCPO_MA_SEG:    decode_reg = DCPO_REG_SEG;
			`DCPO_MA_CNT_LO: decode_reg = DCPO_REG_CNT_LO;
			`DCPO_MA_CNT_HI: decode_reg = DCPO_REG_CNT_HI;
			default:         decode_reg = DCPO_REG_NONE;
		endcase
	endfunction : decode_reg

	dcpo_reg_e              wr_sel;
	dcpo_reg_e              rd_sel;
	dcpo_byte_t             inv_q  [`DCPO_CHANNELS];
	dcpo_byte_t             bank_q [`DCPO_CHANNELS];
	dcpo_byte_t             seg_q  [`DCPO_CHANNELS];
	logic [`DCPO_CNT_W-1:0] cnt_q;
	dcpo_byte_t             rd_data;
	logic [2:0]             seg_idx;
	logic                   start_sys;
	logic [`DCPO_CNT_W-1:0] word_link;
	logic                   word_valid;
	logic [`DCPO_CNT_W-1:0] osc_cnt_q;
	logic [`DCPO_CNT_W-1:0] sent_q;
	logic                   osc_run_q;
	logic                   send_ready;
	logic                   send_valid;

	assign wr_sel = mrw_valid ? decode_reg(mr_addr) : DCPO_REG_NONE;
	assign rd_sel = mrr_valid ? decode_reg(mr_addr) : DCPO_REG_NONE;

	////////////////////////////////////////////////////////////////////////////
	// Writable registers, one copy per channel

	for (genvar c = 0; c < `DCPO_CHANNELS; c++) begin : g_chan
		always_ff @(posedge clk_link or posedge reset) begin
			if (reset) begin
				inv_q[c]  <= `DCPO_INV_RST;
				bank_q[c] <= `DCPO_BANK_RST;
				seg_q[c]  <= `DCPO_SEG_RST;
			end else if (mr_chan == 1'(c)) begin
				case (wr_sel)
					DCPO_REG_INV:  inv_q[c]  <= mrw_data;
					DCPO_REG_BANK: bank_q[c] <= mrw_data;
					DCPO_REG_SEG:  seg_q[c]  <= mrw_data;
					default: ;
				endcase
			end
		end

		assign bank_mask[c] = bank_q[c];
		assign seg_mask[c]  = seg_q[c];
	end

	////////////////////////////////////////////////////////////////////////////
	// Count copy on the link side; the start command wins over a late word

	always_ff @(posedge clk_link or posedge reset) begin
		if (reset) begin
			cnt_q <= `DCPO_CNT_RST;
		end else if (mpc_osc_start) begin
			cnt_q <= `DCPO_CNT_RST;
		end else if (word_valid) begin
			cnt_q <= word_link;
		end
	end

	always_comb begin
		case (rd_sel)
			DCPO_REG_CNT_LO: rd_data = cnt_q[7:0];
			DCPO_REG_CNT_HI: rd_data = cnt_q[15:8];
			default:         rd_data = `DCPO_RD_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Data pins: calibration output takes priority over a register read

	always_ff @(posedge clk_link or posedge reset) begin
		if (reset) begin
			dq_o   <= '0;
			dq_oe  <= 1'b0;
			dmi_o  <= 1'b0;
			dmi_oe <= 1'b0;
		end else if (cal_active) begin
			dq_o   <= {`DCPO_OP_W{cal_pattern}} ^ inv_q[cal_chan];
			dq_oe  <= 1'b1;
			dmi_o  <= cal_pattern;
			dmi_oe <= 1'b1;
		end else if (mrr_valid) begin
			dq_o   <= rd_data;
			dq_oe  <= 1'b1;
			dmi_o  <= 1'b0;
			dmi_oe <= 1'b1;
		end else begin
			dq_o   <= '0;
			dq_oe  <= 1'b0;
			dmi_o  <= 1'b0;
			dmi_oe <= 1'b0;
		end
	end

	always_ff @(posedge clk_link or posedge reset) begin
		if (reset) begin
			dbi_active <= 1'b0;
		end else begin
			dbi_active <= dbi_enable & ~cal_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Refresh filter for self refresh

	assign seg_idx = byte_mode ? ref_row[`DCPO_SEG_LSB_BYTE +: 3] : ref_row[`DCPO_SEG_LSB +: 3];

	always_ff @(posedge clk_link or posedge reset) begin
		if (reset) begin
			ref_done <= 1'b0;
			ref_skip <= 1'b0;
		end else begin
			ref_done <= ref_req;
			ref_skip <= ref_req & (bank_q[ref_chan][ref_bank] | seg_q[ref_chan][seg_idx]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator counter, system clock side

	dcpo_pulse_sync u_start_sync (
		.src_clk   (clk_link),
		.dst_clk   (clk_sys),
		.reset     (reset),
		.src_pulse (mpc_osc_start),
		.dst_pulse (start_sys)
	);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			osc_run_q <= 1'b0;
		end else if (start_sys) begin
			osc_run_q <= 1'b1;
		end else if (osc_stop) begin
			osc_run_q <= 1'b0;
		end
	end

	// Saturates rather than wraps so a long run never reads as short
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			osc_cnt_q <= `DCPO_CNT_RST;
		end else if (start_sys) begin
			osc_cnt_q <= `DCPO_CNT_RST;
		end else if (osc_run_q && osc_tick && (osc_cnt_q != '1)) begin
			osc_cnt_q <= osc_cnt_q + 1'b1;
		end
	end

	assign osc_running = osc_run_q;
	assign send_valid  = (osc_cnt_q != sent_q);

	// A word in flight at start may land stale; the next send repairs it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sent_q <= `DCPO_CNT_RST;
		end else if (send_valid && send_ready) begin
			sent_q <= osc_cnt_q;
		end
	end

	dcpo_word_sync #(
		.W (`DCPO_CNT_W)
	) u_cnt_sync (
		.src_clk   (clk_sys),
		.dst_clk   (clk_link),
		.reset     (reset),
		.src_data  (osc_cnt_q),
		.src_valid (send_valid),
		.src_ready (send_ready),
		.dst_data  (word_link),
		.dst_valid (word_valid)
	);

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_inv_default;
		@(posedge clk_link) disable iff (reset)
		$fell(reset) |-> (inv_q[0] == `DCPO_INV_RST) && (inv_q[1] == `DCPO_INV_RST);
	endproperty
	a_inv_default: assert property (p_inv_default) else $error("invert reset value wrong");

	property p_inv_write;
		@(posedge clk_link) disable iff (reset)
		(wr_sel == DCPO_REG_INV) |=> (inv_q[$past(mr_chan)] == $past(mrw_data));
	endproperty
	a_inv_write: assert property (p_inv_write) else $error("invert write lost");

	property p_cal_map;
		@(posedge clk_link) disable iff (reset)
		cal_active |=>
			dq_oe && (dq_o == ({`DCPO_OP_W{$past(cal_pattern)}} ^ $past(inv_q[cal_chan])));
	endproperty
	a_cal_map: assert property (p_cal_map) else $error("calibration line inversion wrong");

	property p_dmi_true;
		@(posedge clk_link) disable iff (reset)
		cal_active |=> dmi_oe && (dmi_o == $past(cal_pattern));
	endproperty
	a_dmi_true: assert property (p_dmi_true) else $error("mask pin inverted in calibration");

	property p_no_dbi;
		@(posedge clk_link) disable iff (reset)
		cal_active |=> !dbi_active;
	endproperty
	a_no_dbi: assert property (p_no_dbi) else $error("bus inversion during calibration");

	property p_mask_default;
		@(posedge clk_link) disable iff (reset)
		$fell(reset) |-> (bank_mask == '0) && (seg_mask == '0);
	endproperty
	a_mask_default: assert property (p_mask_default) else $error("masks not cleared at reset");

	property p_bank_chan;
		@(posedge clk_link) disable iff (reset)
		(wr_sel == DCPO_REG_BANK) |=>
			(bank_q[$past(mr_chan)] == $past(mrw_data)) && (bank_q[!$past(mr_chan)] == $past(bank_q[!mr_chan]));
	endproperty
	a_bank_chan: assert property (p_bank_chan) else $error("bank mask channel mixup");

	property p_bank_skip;
		@(posedge clk_link) disable iff (reset)
		(ref_req && bank_q[ref_chan][ref_bank]) |=> ref_done && ref_skip;
	endproperty
	a_bank_skip: assert property (p_bank_skip) else $error("masked bank was refreshed");

	property p_seg_byte;
		@(posedge clk_link) disable iff (reset)
		(ref_req && !bank_q[ref_chan][ref_bank] && byte_mode) |=>
			ref_done && (ref_skip == $past(seg_q[ref_chan][ref_row[`DCPO_SEG_LSB_BYTE +: 3]]));
	endproperty
	a_seg_byte: assert property (p_seg_byte) else $error("byte mode segment decode wrong");

	property p_seg_skip;
		@(posedge clk_link) disable iff (reset)
		(ref_req && !bank_q[ref_chan][ref_bank] && !byte_mode) |=>
			ref_done && (ref_skip == $past(seg_q[ref_chan][ref_row[`DCPO_SEG_LSB +: 3]]));
	endproperty
	a_seg_skip: assert property (p_seg_skip) else $error("segment refresh filter wrong");

	property p_seg_chan;
		@(posedge clk_link) disable iff (reset)
		(wr_sel == DCPO_REG_SEG) |=>
			(seg_q[$past(mr_chan)] == $past(mrw_data)) && (seg_q[!$past(mr_chan)] == $past(seg_q[!mr_chan]));
	endproperty
	a_seg_chan: assert property (p_seg_chan) else $error("segment mask channel mixup");

	property p_read_lo;
		@(posedge clk_link) disable iff (reset)
		(rd_sel == DCPO_REG_CNT_LO && !cal_active) |=> dq_oe && (dq_o == $past(cnt_q[7:0]));
	endproperty
	a_read_lo: assert property (p_read_lo) else $error("low count read wrong");

	property p_read_hi;
		@(posedge clk_link) disable iff (reset)
		(rd_sel == DCPO_REG_CNT_HI && !cal_active) |=> dq_oe && (dq_o == $past(cnt_q[15:8]));
	endproperty
	a_read_hi: assert property (p_read_hi) else $error("high count read wrong");

	property p_start_clear;
		@(posedge clk_sys) disable iff (reset)
		start_sys |=> (osc_cnt_q == `DCPO_CNT_RST) && osc_run_q;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start did not clear count");

	property p_read_zero;
		@(posedge clk_link) disable iff (reset)
		(mrr_valid && !cal_active && rd_sel inside {DCPO_REG_INV, DCPO_REG_BANK, DCPO_REG_SEG, DCPO_REG_NONE})
			|=> dq_oe && (dq_o == `DCPO_RD_ZERO) && !dmi_o;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("unused read lines not zero");

	property p_ro_ignore;
		@(posedge clk_link) disable iff (reset)
		(wr_sel inside {DCPO_REG_CNT_LO, DCPO_REG_CNT_HI} && !word_valid && !mpc_osc_start)
			|=> $stable(cnt_q) && $stable(bank_q[0]) && $stable(seg_q[0]) && $stable(inv_q[0]);
	endproperty
	a_ro_ignore: assert property (p_ro_ignore) else $error("write to count register took effect");

endmodule : dcpo_mode_regs

`default_nettype wire

// ==== tb/dcpo_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dcpo_defs.svh"

// Controller side of the mode register command path. Released lines carry
// the inverse of their last value so a late sample cannot pass by luck.
module dcpo_ctrl_model
	import dcpo_pkg::*;
#(
	parameter bit SEG_TOP_ABSENT = 1'b0
) (
	input  wire logic       clk_link,
	input  wire logic [7:0] dq_o,
	input  wire logic       dq_oe,
	output logic            mrw_valid,
	output logic            mrr_valid,
	output logic            mr_chan,
	output logic [5:0]      mr_addr,
	output logic [7:0]      mrw_data,
	output logic            mpc_osc_start
);
	initial begin
		mrw_valid = 1'b0;
		mrr_valid = 1'b0;
		mr_chan = 1'b0;
		mr_addr = 6'h00;
		mrw_data = 8'h00;
		mpc_osc_start = 1'b0;
	end

	task automatic mr_write(input logic ch, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_link);
		mr_chan <= ch;
		mr_addr <= a;
		mrw_data <= d;
		mrw_valid <= 1'b1;
		@(posedge clk_link);
		mrw_valid <= 1'b0;
		mr_chan <= ~ch;
		mr_addr <= ~a;
		mrw_data <= ~d;
	endtask : mr_write

	// Densities without the top two segments get those bits forced low
	task automatic seg_write(input logic ch, input logic [7:0] d);
		mr_write(ch, `DCPO_MA_SEG, SEG_TOP_ABSENT ? {2'b00, d[5:0]} : d);
	endtask : seg_write

	// A gap before the request models a slow controller
	task automatic mr_read(input int gap, input logic ch, input logic [5:0] a, output logic [7:0] d, output logic oe);
		repeat (gap) @(posedge clk_link);
		@(posedge clk_link);
		mr_chan <= ch;
		mr_addr <= a;
		mrr_valid <= 1'b1;
		@(posedge clk_link);
		mrr_valid <= 1'b0;
		mr_chan <= ~ch;
		mr_addr <= ~a;
		#1;
		oe = dq_oe;
		d = dq_o;
	endtask : mr_read

	// Both halves fetched and joined; oe is set only if both reads drove the lines
	task automatic read_count(output logic [15:0] cnt, output logic oe);
		logic [7:0] lo;
		logic [7:0] hi;
		logic       oe_lo;
		logic       oe_hi;
		mr_read(0, 1'b0, `DCPO_MA_CNT_LO, lo, oe_lo);
		mr_read(2, 1'b0, `DCPO_MA_CNT_HI, hi, oe_hi);
		cnt = {hi, lo};
		oe = oe_lo & oe_hi;
	endtask : read_count

	task automatic osc_start();
		@(posedge clk_link);
		mpc_osc_start <= 1'b1;
		@(posedge clk_link);
		mpc_osc_start <= 1'b0;
	endtask : osc_start
endmodule : dcpo_ctrl_model
`default_nettype wire

// ==== tb/test_dcpo_mode_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dcpo_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end

module test_dcpo_mode_regs;
	import dcpo_pkg::*;
	logic clk_sys, clk_link, reset, mrw_valid, mrr_valid, mr_chan, mpc_osc_start;
	logic cal_active, cal_chan, cal_pattern, dbi_enable, ref_req, ref_chan, byte_mode;
	logic osc_tick, osc_stop, dq_oe, dmi_o, dmi_oe, dbi_active, ref_done, ref_skip, osc_running;
	logic [5:0] mr_addr;
	logic [7:0] mrw_data, dq_o, rd;
	logic [2:0] ref_bank;
	logic [14:0] ref_row;
	logic [1:0][7:0] bank_mask, seg_mask;
	logic [15:0] cnt;
	logic oe;
	int errors, n_compared, cycles;

	dcpo_mode_regs uut (.clk_sys(clk_sys), .clk_link(clk_link), .reset(reset), .mrw_valid(mrw_valid),
		.mrr_valid(mrr_valid), .mr_chan(mr_chan), .mr_addr(mr_addr), .mrw_data(mrw_data),
		.mpc_osc_start(mpc_osc_start), .cal_active(cal_active), .cal_chan(cal_chan),
		.cal_pattern(cal_pattern), .dbi_enable(dbi_enable), .ref_req(ref_req), .ref_chan(ref_chan),
		.ref_bank(ref_bank), .ref_row(ref_row), .byte_mode(byte_mode), .osc_tick(osc_tick),
		.osc_stop(osc_stop), .dq_o(dq_o), .dq_oe(dq_oe), .dmi_o(dmi_o), .dmi_oe(dmi_oe),
		.dbi_active(dbi_active), .bank_mask(bank_mask), .seg_mask(seg_mask), .ref_done(ref_done),
		.ref_skip(ref_skip), .osc_running(osc_running));

	dcpo_ctrl_model model (.clk_link(clk_link), .dq_o(dq_o), .dq_oe(dq_oe), .mrw_valid(mrw_valid),
		.mrr_valid(mrr_valid), .mr_chan(mr_chan), .mr_addr(mr_addr), .mrw_data(mrw_data),
		.mpc_osc_start(mpc_osc_start));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Link clock offset so its edges never line up with the system clock
	initial begin
		clk_link = 1'b0;
		#3;
		forever #6 clk_link = ~clk_link;
	end

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic cal_beat(input logic ch, input logic pat, input logic [7:0] exp);
		@(posedge clk_link);
		cal_active <= 1'b1;
		cal_chan <= ch;
		cal_pattern <= pat;
		@(posedge clk_link);
		cal_active <= 1'b0;
		cal_pattern <= ~pat;
		#1;
		`CHK(dq_oe, 1'b1)
		`CHK(dq_o, exp)
		`CHK(dmi_o, pat)
		`CHK(dmi_oe, 1'b1)
		`CHK(dbi_active, 1'b0)
	endtask : cal_beat

	task automatic ref_check(input logic ch, input logic [2:0] b, input logic [14:0] row, input logic bm,
		input logic exp);
		@(posedge clk_link);
		ref_req <= 1'b1;
		ref_chan <= ch;
		ref_bank <= b;
		ref_row <= row;
		byte_mode <= bm;
		@(posedge clk_link);
		ref_req <= 1'b0;
		#1;
		`CHK(ref_done, 1'b1)
		`CHK(ref_skip, exp)
	endtask : ref_check

	task automatic rd_check(input logic [5:0] a, input logic [7:0] exp);
		model.mr_read(0, 1'b1, a, rd, oe);
		`CHK(oe, 1'b1)
		`CHK(rd, exp)
	endtask : rd_check

	task automatic sys_pulse(input bit stop);
		@(posedge clk_sys);
		if (stop) osc_stop <= 1'b1;
		else osc_tick <= 1'b1;
		@(posedge clk_sys);
		osc_tick <= 1'b0;
		osc_stop <= 1'b0;
	endtask : sys_pulse

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{cal_active, cal_chan, cal_pattern, ref_req, ref_chan, byte_mode, osc_tick, osc_stop} = 8'h00;
		ref_bank = 3'h0;
		ref_row = 15'h0000;
		dbi_enable = 1'b1;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		reset = 1'b1;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;

		@(posedge clk_link);
		#1;
		`CHK(bank_mask, 16'h0000)
		`CHK(seg_mask, 16'h0000)
		cal_beat(1'b0, 1'b1, 8'haa);
		cal_beat(1'b1, 1'b1, 8'haa);
		$display("test reset_values done");

		model.mr_write(1'b1, `DCPO_MA_INV, 8'h15);
		cal_beat(1'b1, 1'b0, 8'h15);
		cal_beat(1'b1, 1'b1, 8'hea);
		cal_beat(1'b0, 1'b0, 8'h55);
		@(posedge clk_link);
		#1;
		`CHK(dbi_active, 1'b1)
		$display("test invert done");

		model.mr_write(1'b1, `DCPO_MA_BANK, 8'ha5);
		model.seg_write(1'b0, 8'h3c);
		@(posedge clk_link);
		#1;
		`CHK(bank_mask, 16'ha500)
		`CHK(seg_mask, 16'h003c)
		ref_check(1'b1, 3'd2, 15'h0000, 1'b0, 1'b1);
		ref_check(1'b1, 3'd1, 15'h0000, 1'b0, 1'b0);
		ref_check(1'b0, 3'd2, 15'h0000, 1'b0, 1'b0);
		ref_check(1'b0, 3'd0, 15'h1000, 1'b0, 1'b1);
		ref_check(1'b0, 3'd0, 15'h0800, 1'b0, 1'b0);
		ref_check(1'b0, 3'd0, 15'h1000, 1'b1, 1'b0);
		ref_check(1'b0, 3'd0, 15'h3000, 1'b1, 1'b1);
		ref_check(1'b1, 3'd1, 15'h1000, 1'b0, 1'b0);
		rd_check(`DCPO_MA_BANK, 8'h00);
		rd_check(6'h20, 8'h00);
		$display("test masks done");

		model.osc_start();
		repeat (10) @(posedge clk_sys);
		#1;
		`CHK(osc_running, 1'b1)
		repeat (291) sys_pulse(1'b0);
		sys_pulse(1'b1);
		repeat (20) @(posedge clk_sys);
		model.read_count(cnt, oe);
		`CHK(oe, 1'b1)
		`CHK(cnt, 16'h0123)
		model.mr_write(1'b0, `DCPO_MA_CNT_LO, 8'hff);
		model.mr_write(1'b0, `DCPO_MA_CNT_HI, 8'hff);
		repeat (10) @(posedge clk_sys);
		model.read_count(cnt, oe);
		`CHK(cnt, 16'h0123)
		model.osc_start();
		repeat (20) @(posedge clk_sys);
		model.read_count(cnt, oe);
		`CHK(cnt, 16'h0000)
		$display("test oscillator done");
		test_done();
	end
endmodule : test_dcpo_mode_regs
`default_nettype wire
